// File: design/odu_pkg.sv
// Shared constants and types of the octal converter update control.
// Assumes a 50 MHz system clock and 24-bit command words.
package odu_pkg;
   // ******************************************************
   // Sizes
   // ******************************************************
   localparam int NCH    = 8;        // Number of converter channels.
   localparam int DW     = 16;       // Data field and code width.
   localparam int CMD_W  = 24;       // Command word width.
   localparam int MASK_W = 8;        // Load strobe mask width.
   localparam int PD_W   = 16;       // Power-down select width.
   localparam int SET_W  = 3;        // Reference and gain setup width.
   typedef logic [DW-1:0]          code_t;  // One channel code.
   typedef logic [NCH-1:0][DW-1:0] bank_t;  // All channel codes.

   // ******************************************************
   // Command word fields
   // ******************************************************
   localparam int CMD_HI  = 23;      // Command code, top bit.
   localparam int CMD_LO  = 20;      // Command code, bottom bit.
   localparam int ADR_HI  = 19;      // Address field, top bit.
   localparam int ADR_LO  = 16;      // Address field, bottom bit.
   localparam int PD_ZERO_BIT  = 19; // Must be zero for power-down.
   localparam int SET_REF_BIT  = 0;  // Setup bit: reference off.
   localparam int SET_GAIN_BIT = 2;  // Setup bit: gain of two.

   // ******************************************************
   // Command codes
   // ******************************************************
   localparam logic [3:0] CMD_WR_IN  = 4'h1; // Write input register.
   localparam logic [3:0] CMD_UPD    = 4'h2; // Copy input to DAC register.
   localparam logic [3:0] CMD_WR_UPD = 4'h3; // Write both registers.
   localparam logic [3:0] CMD_PD     = 4'h4; // Power-down select.
   localparam logic [3:0] CMD_MASK   = 4'h5; // Load strobe mask.
   localparam logic [3:0] CMD_SWRST  = 4'h6; // Keyed software reset.
   localparam logic [3:0] CMD_SETUP  = 4'h7; // Reference and gain setup.
   localparam logic [3:0] SWRST_ADDR = 4'h0;     // Reset address key.
   localparam code_t      SWRST_KEY  = 16'h1234; // Reset data key.

   // ******************************************************
   // Reset values and clear codes
   // ******************************************************
   localparam code_t             CODE_ZERO = 16'h0000; // Zero scale.
   localparam code_t             CODE_MID  = 16'h8000; // Midscale.
   localparam logic [MASK_W-1:0] MASK_RST  = 8'h00;
   localparam logic [PD_W-1:0]   PD_RST    = 16'h0000;
   localparam logic [SET_W-1:0]  SET_RST   = 3'h0;

   // ******************************************************
   // Pins and timing
   // ******************************************************
   localparam int PIN_N   = 3;       // Synchronised pins.
   localparam int PIN_STB = 0;       // Load strobe, active low.
   localparam int PIN_HWR = 1;       // Hardware reset, active low.
   localparam int PIN_SEL = 2;       // Reset level select.
   localparam logic [PIN_N-1:0] PIN_RST = 3'h3; // Idle pin levels.
   localparam int CLK_NS      = 20;  // System clock period.
   localparam int POR_TIME_NS = 200; // Power-on settle time.
   localparam logic [3:0] POR_CYC =
      4'((POR_TIME_NS + CLK_NS - 1) / CLK_NS);
endpackage

// File: design/odu_cmd_if.sv
// Command word handed from the link crossing to the decoder.
// Assumes both sides run on the system clock.
`timescale 1ns/1ns
interface odu_cmd_if;
   logic [odu_pkg::CMD_W-1:0] word;   // Captured command word.
   logic                      strobe; // One-cycle pulse, word valid.
   modport src (output word, output strobe);
   modport dst (input word, input strobe);
endinterface // odu_cmd_if

// File: design/odu_pin_sync.sv
// Two-flop synchronisers for asynchronous device pins.
// Assumes pins change slowly compared with the system clock.
`timescale 1ns/1ns
module odu_pin_sync
   #(parameter int W = 1,
     parameter logic [W-1:0] RST_VAL = '0)
(
   // Clock, reset and enable.
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   // Pins in, levels out.
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);
   logic [W-1:0] meta; // First stage, read only by the second.

   // ******************************************************
   // Per-pin flop pairs
   // ******************************************************
   for (genvar g = 0; g < W; g++)
   begin : g_sync
      // Both stages hold the idle level during reset.
      always_ff @(posedge i_clk)
      begin
         if (!i_rst_n)
         begin
            meta[g]    <= RST_VAL[g];
            o_level[g] <= RST_VAL[g];
         end
         else if (i_ce)
         begin
            meta[g]    <= i_pin[g];
            o_level[g] <= meta[g];
         end
      end
   end
endmodule // odu_pin_sync

// File: design/odu_cmd_cdc.sv
// Toggle handshake that carries command words from link to system clock.
// Assumes the bus controller offers a word with valid and waits for ready.
`timescale 1ns/1ns
module odu_cmd_cdc
(
   // Clocks, reset and enable.
   input  wire logic                      i_clk_link,
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_ce,
   // Link side.
   input  wire logic [odu_pkg::CMD_W-1:0] i_link_word,
   input  wire logic                      i_link_valid,
   output logic                           o_link_ready,
   // System side.
   odu_cmd_if.src                         cmd
);
   import odu_pkg::*;

   logic             lrst_s1;  // Reset sync, first stage.
   logic             lrst_n;   // Reset in the link domain.
   logic             req;      // Link request toggle.
   logic [CMD_W-1:0] hold;     // Word held until acknowledged.
   logic             ack_s1;   // Acknowledge sync, first stage.
   logic             ack_s2;   // Acknowledge in the link domain.
   logic             req_s1;   // Request sync, first stage.
   logic             req_s2;   // Request in the system domain.
   logic             ack;      // System acknowledge toggle.
   logic             take;     // Word accepted this link cycle.

   assign take = i_link_valid && o_link_ready;

   // ******************************************************
   // Link domain
   // ******************************************************
   // The system reset reaches the link logic through two flops.
   always_ff @(posedge i_clk_link)
   begin
      lrst_s1 <= i_rst_n;
      lrst_n  <= lrst_s1;
   end

   // Capture a word and flip the request; the word stays put until acked.
   always_ff @(posedge i_clk_link)
   begin
      if (!lrst_n)
      begin
         req  <= 1'b0;
         hold <= '0;
      end
      else if (take)
      begin
         req  <= ~req;
         hold <= i_link_word;
      end
   end

   // Ready returns only once the system side has echoed the toggle.
   always_ff @(posedge i_clk_link)
   begin
      if (!lrst_n)
      begin
         ack_s1       <= 1'b0;
         ack_s2       <= 1'b0;
         o_link_ready <= 1'b0;
      end
      else
      begin
         ack_s1       <= ack;
         ack_s2       <= ack_s1;
         o_link_ready <= !take && (ack_s2 == req);
      end
   end

   // ******************************************************
   // System domain
   // ******************************************************
   // A changed request yields one strobe; hold is stable by then.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         req_s1     <= 1'b0;
         req_s2     <= 1'b0;
         ack        <= 1'b0;
         cmd.strobe <= 1'b0;
         cmd.word   <= '0;
      end
      else if (i_ce)
      begin
         req_s1     <= req;
         req_s2     <= req_s1;
         ack        <= req_s2;
         cmd.strobe <= (req_s2 != ack);
         if (req_s2 != ack)
         begin
            cmd.word <= hold;
         end
      end
   end
endmodule // odu_cmd_cdc

// File: design/odu_top.sv
// Octal converter update control: command decode, input and DAC register
// banks, load strobe with mask, power-down select, resets and setup.
// Assumes command words arrive from a bus controller on the link clock
// and that pins are asynchronous to the system clock.
// How it works
// - Strobe high write loads input; fall copies.
// - Power-down code 0100, bit 19 zero.
// - Command 0101 loads mask, address ignored.
// - Mask clears to zero at reset.
// - Masked channel ignores strobe, sees high.
// - Write input; DAC follows only strobe low.
// - Command 0010 copies input to DAC.
// - Command 0011 writes both registers.
// - Strobe falling edge loads unmasked channels.
// - Strobe held low ignores mask on writes.
// - Reset pin clears to zero or midscale.
// - Reset pin low blocks updates; clear holds.
// - Strobe pin ignored during power-on reset.
// - Power-up code chosen by level select.
// - Keyed command 0110 restarts power-on state.
// - Setup bit 0 turns reference off.
// - Setup bit 2 selects gain two.
// - Mode bits: 00 normal, 01 ground, 11 open.
// - Power-down keeps registers, still writable.
`timescale 1ns/1ns
module odu_top
(
   // Clocks, reset and enable.
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_clk_link,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_ce,
   // Command words from the bus controller, link clock.
   input  wire logic [odu_pkg::CMD_W-1:0]  i_link_word,
   input  wire logic                       i_link_valid,
   output logic                            o_link_ready,
   // Device pins, asynchronous.
   input  wire logic                       i_load_strobe_n,
   input  wire logic                       i_hw_reset_n,
   input  wire logic                       i_reset_level_select,
   // Converter controls.
   output odu_pkg::bank_t                  o_dac_code,
   output logic [odu_pkg::PD_W-1:0]        o_powerdown_mode,
   output logic                            o_ref_off,
   output logic                            o_gain_two,
   output logic                            o_por_busy
);
   import odu_pkg::*;

   // ******************************************************
   // Declarations
   // ******************************************************
   odu_cmd_if               cif ();      // Decoded command carrier.
   logic [PIN_N-1:0]        pin_lvl;     // Synchronised pin levels.
   logic                    stb_prev;    // Strobe level a cycle ago.
   logic                    stb_low;     // Strobe pin seen low.
   logic                    stb_fall;    // Strobe falling edge.
   logic                    hw_low;      // Reset pin held low.
   code_t                   clr_code;    // Clear code from level select.
   bank_t                   inp;         // Input registers.
   logic [MASK_W-1:0]       load_strobe_mask;
   logic [PD_W-1:0]         channel_power_down_select; // Power-down select register.
   logic [SET_W-1:0]        reference_gain_setup;
   logic [3:0]              por_cnt;     // Power-on settle counter.
   logic                    soft_rst;    // Keyed reset, one cycle.
   logic                    sys_rst;     // Any restart of the state.
   logic                    ok;          // Register updates allowed.
   logic [3:0]              op;          // Command code field.
   logic [3:0]              adr;         // Address field.
   code_t                   dat;         // Data field.
   logic                    take;        // Command taken this cycle.

   // Address decode; codes eight and up select no channel.
   function automatic logic chan_hit(input logic [3:0] a, input int n);
      chan_hit = (a == 4'(n));
   endfunction

   assign o_powerdown_mode = channel_power_down_select;

   // ******************************************************
   // Link crossing and pin synchronisers
   // ******************************************************
   odu_cmd_cdc u_cdc
   (
      .i_clk_link   (i_clk_link),
      .i_clk_sys    (i_clk_sys),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_link_word  (i_link_word),
      .i_link_valid (i_link_valid),
      .o_link_ready (o_link_ready),
      .cmd          (cif.src)
   );

   odu_pin_sync #(.W(PIN_N), .RST_VAL(PIN_RST)) u_pins
   (
      .i_clk   (i_clk_sys),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_pin   ({i_reset_level_select, i_hw_reset_n, i_load_strobe_n}),
      .o_level (pin_lvl)
   );

   // ******************************************************
   // Decode
   // ******************************************************
   assign op       = cif.word[CMD_HI:CMD_LO];
   assign adr      = cif.word[ADR_HI:ADR_LO];
   assign dat      = cif.word[DW-1:0];
   assign take     = cif.strobe;
   assign stb_low  = !pin_lvl[PIN_STB];
   assign hw_low   = !pin_lvl[PIN_HWR];
   assign stb_fall = stb_prev && stb_low;
   assign clr_code = pin_lvl[PIN_SEL] ? CODE_MID : CODE_ZERO;
   assign sys_rst  = !i_rst_n || soft_rst;
   // The strobe pin and data writes count for nothing while settling.
   assign ok       = !o_por_busy && !hw_low && !soft_rst;
   assign o_ref_off  = reference_gain_setup[SET_REF_BIT];
   assign o_gain_two = reference_gain_setup[SET_GAIN_BIT];

   // Edge detector works on the settled level only.
   always_ff @(posedge i_clk_sys)
   begin
      if (sys_rst)
      begin
         stb_prev <= 1'b0;
      end
      else if (i_ce)
      begin
         stb_prev <= !stb_low;
      end
   end

   // ******************************************************
   // Power-on settle and keyed reset
   // ******************************************************
   // The count waits while the reset pin is low, since the device cannot
   // finish starting up until that pin is released.
   always_ff @(posedge i_clk_sys)
   begin
      if (sys_rst)
      begin
         por_cnt    <= POR_CYC;
         o_por_busy <= 1'b1;
      end
      else if (i_ce && o_por_busy && !hw_low)
      begin
         por_cnt    <= por_cnt - 4'h1;
         o_por_busy <= (por_cnt != 4'h1);
      end
   end

   // Only the exact address and data key restart the block.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         soft_rst <= 1'b0;
      end
      else if (i_ce)
      begin
         soft_rst <= take && !soft_rst && (op == CMD_SWRST)
                     && (adr == SWRST_ADDR) && (dat == SWRST_KEY);
      end
   end

   // ******************************************************
   // Control registers
   // ******************************************************
   // Mask, power-down and setup writes; other codes leave them alone.
   always_ff @(posedge i_clk_sys)
   begin
      if (sys_rst)
      begin
         load_strobe_mask     <= MASK_RST;
         channel_power_down_select <= PD_RST;
         reference_gain_setup <= SET_RST;
      end
      else if (i_ce && take)
      begin
         if (op == CMD_MASK)
         begin
            load_strobe_mask <= dat[MASK_W-1:0];
         end
         else if (op == CMD_PD && !cif.word[PD_ZERO_BIT])
         begin
            // Two bits per channel; codes are passed to the output stage.
            channel_power_down_select <= dat;
         end
         else if (op == CMD_SETUP)
         begin
            reference_gain_setup <= dat[SET_W-1:0];
         end
      end
   end

   // ******************************************************
   // Input and DAC register banks
   // ******************************************************
   // Power-down state is not looked at here: registers keep and accept
   // data whatever mode a channel is in.
   always_ff @(posedge i_clk_sys)
   begin
      if (sys_rst)
      begin
         inp        <= '0;
         o_dac_code <= '0;
      end
      else if (i_ce)
      begin
         for (int n = 0; n < NCH; n++)
         begin
            if (!ok)
            begin
               // Hold the clear code until settled and the pin is high.
               inp[n]        <= clr_code;
               o_dac_code[n] <= clr_code;
            end
            else if (take && chan_hit(adr, n) && op == CMD_WR_IN)
            begin
               inp[n] <= dat;
               // A low strobe updates at once, mask or not.
               if (stb_low)
               begin
                  o_dac_code[n] <= dat;
               end
               else if (stb_fall && !load_strobe_mask[n])
               begin
                  o_dac_code[n] <= inp[n];
               end
            end
            else if (take && chan_hit(adr, n) && op == CMD_WR_UPD)
            begin
               inp[n]        <= dat;
               o_dac_code[n] <= dat;
            end
            else if (take && chan_hit(adr, n) && op == CMD_UPD)
            begin
               o_dac_code[n] <= inp[n];
            end
            else if (stb_fall && !load_strobe_mask[n])
            begin
               // A masked channel never gets here; it sees the pin high.
               o_dac_code[n] <= inp[n];
            end
         end
      end
   end

   // ******************************************************
   // Checks
   // ******************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n || !i_ce);

   sequence s_key_seen;
      take && !soft_rst && op == CMD_SWRST && adr == SWRST_ADDR
      && dat == SWRST_KEY;
   endsequence
   sequence s_restart;
      soft_rst ##1 (o_por_busy && load_strobe_mask == MASK_RST);
   endsequence

   chk_soft_reset_key: assert property (s_key_seen |=> s_restart)
      else $error("keyed reset did not restart");
   // A wrong address or a wrong data key must both leave the block alone.
   chk_soft_reset_bad: assert property (
      take && op == CMD_SWRST && (adr != SWRST_ADDR || dat != SWRST_KEY)
      |=> !soft_rst)
      else $error("unkeyed reset executed");
   chk_mask_load: assert property (
      take && !soft_rst && op == CMD_MASK
      |=> load_strobe_mask == $past(dat[MASK_W-1:0]))
      else $error("mask not loaded");
   chk_pd_load: assert property (
      take && !soft_rst && op == CMD_PD
      && !cif.word[PD_ZERO_BIT] |=> o_powerdown_mode == $past(dat))
      else $error("power-down select not loaded");
   chk_setup_load: assert property (
      take && !soft_rst && op == CMD_SETUP
      |=> o_ref_off == $past(dat[SET_REF_BIT])
      && o_gain_two == $past(dat[SET_GAIN_BIT]))
      else $error("setup not loaded");
   // A strobe edge or a forced clear may move the DAC codes legally, so
   // only quiet cycles are judged here.
   chk_bad_cmd_ignored: assert property (
      ok && !stb_fall && take && !soft_rst
      && (op == 4'h0 || op > CMD_SETUP)
      |=> $stable(load_strobe_mask) && $stable(o_powerdown_mode)
      && $stable(inp) && $stable(o_dac_code))
      else $error("undefined command changed state");

   // Per-channel checks, one copy for every channel.
   for (genvar g = 0; g < NCH; g++)
   begin : g_chk
      chk_copy_cmd: assert property (
         ok && take && chan_hit(adr, g) && op == CMD_UPD
         |=> o_dac_code[g] == $past(inp[g]) && $stable(inp[g]))
         else $error("copy command wrong");
      chk_defer_write: assert property (
         ok && take && chan_hit(adr, g) && op == CMD_WR_IN && !stb_low
         |=> inp[g] == $past(dat) && $stable(o_dac_code[g]))
         else $error("deferred write touched DAC register");
      chk_strobe_fall: assert property (
         ok && stb_fall && !take
         |=> o_dac_code[g] == ($past(load_strobe_mask[g])
         ? $past(o_dac_code[g]) : $past(inp[g])))
         else $error("strobe edge handled wrong");
   end

   chk_hw_clear: assert property (
      !o_por_busy && hw_low ##1 hw_low
      |=> o_dac_code[0] == $past(clr_code))
      else $error("reset pin did not clear");
endmodule // odu_top

// File: tb/odu_link_model.sv
// Bus controller stand-in: offers whole command words on the link.
// Assumes the block's valid and ready handshake on the link clock.
`timescale 1ns/1ns
module odu_link_model
(
   // Link clock and handshake.
   input  wire logic                      i_clk_link,
   input  wire logic                      i_ready,
   output logic [odu_pkg::CMD_W-1:0]      o_word,
   output logic                           o_valid
);
   import odu_pkg::*;
   initial o_valid = 1'b0;
   initial o_word = 24'h000000;
   // Hold the word until ready is seen, then scramble the stale word.
   task automatic send(input logic [CMD_W-1:0] w, output logic ok);
      int n;
      n = 0;
      @(posedge i_clk_link);
      o_word <= w;
      o_valid <= 1'b1;
      do
      begin
         @(posedge i_clk_link);
         n++;
      end
      while (i_ready !== 1'b1 && n < 64);
      ok = (n < 64);
      o_valid <= 1'b0;
      o_word <= ~w;
   endtask
endmodule // odu_link_model

// File: tb/octal_dac_update_control_test.sv
// Self-checking bench for the octal converter update control.
// Assumes odu_top and the link model; pins move at falling edges.
`timescale 1ns/1ns
module octal_dac_update_control_test;
   import odu_pkg::*;
   logic clk_sys = 1'b0, clk_link = 1'b0, rst_n = 1'b0;
   logic stb_n = 1'b1, hwr_n = 1'b1, sel = 1'b0, ce = 1'b1;
   logic [CMD_W-1:0] word;
   logic valid, ready, ref_off, gain_two, busy;
   bank_t dac;
   logic [PD_W-1:0] pd;
   int err_count = 0, tests_run = 0;
   always #10 clk_sys = ~clk_sys;
   // Link clock of 15 ns, offset so its edges drift past the others.
   always
   begin
      #7 clk_link = 1'b1;
      #8 clk_link = 1'b0;
   end
   odu_link_model u_link (.i_clk_link(clk_link), .i_ready(ready),
      .o_word(word), .o_valid(valid));
   odu_top u_dut (.i_clk_sys(clk_sys), .i_clk_link(clk_link), .i_rst_n(rst_n),
      .i_ce(ce), .i_link_word(word), .i_link_valid(valid), .o_link_ready(ready),
      .i_load_strobe_n(stb_n), .i_hw_reset_n(hwr_n), .i_reset_level_select(sel),
      .o_dac_code(dac), .o_powerdown_mode(pd), .o_ref_off(ref_off),
      .o_gain_two(gain_two), .o_por_busy(busy));
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("FAIL %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Send one command and let its effect reach the outputs.
   task automatic cmd(input logic [3:0] c, a, input logic [15:0] d);
      logic ok;
      u_link.send({c, a, d}, ok);
      chk("taken", 16'h1, {15'h0, ok});
      wt(10);
   endtask
   task automatic t_power_up;
      chk("busy", 16'h0, {15'h0, busy});
      for (int n = 0; n < NCH; n++)
         chk("dac", CODE_ZERO, dac[n]);
      chk("setup", 16'h0, {14'h0, gain_two, ref_off});
   endtask
   task automatic t_strobe;
      cmd(CMD_WR_IN, 4'h2, 16'h1111);
      chk("dac2", CODE_ZERO, dac[2]);
      stb_n = 1'b0;
      wt(5);
      chk("dac2", 16'h1111, dac[2]);
      stb_n = 1'b1;
      wt(4);
      cmd(CMD_MASK, 4'hf, 16'h0004);
      cmd(CMD_WR_IN, 4'h2, 16'h2222);
      cmd(CMD_WR_IN, 4'h3, 16'h3333);
      stb_n = 1'b0;
      wt(5);
      chk("dac2", 16'h1111, dac[2]);
      chk("dac3", 16'h3333, dac[3]);
      cmd(CMD_WR_IN, 4'h2, 16'h5555);
      chk("dac2", 16'h5555, dac[2]);
      stb_n = 1'b1;
      wt(4);
   endtask
   task automatic t_direct;
      cmd(CMD_WR_UPD, 4'h5, 16'haaaa);
      chk("dac5", 16'haaaa, dac[5]);
      cmd(CMD_WR_IN, 4'h5, 16'hbbbb);
      chk("dac5", 16'haaaa, dac[5]);
      cmd(CMD_UPD, 4'h5, 16'h0000);
      chk("dac5", 16'hbbbb, dac[5]);
   endtask
   // A low clock enable freezes the system side; the word waits, then lands.
   task automatic t_freeze;
      ce = 1'b0;
      cmd(CMD_WR_UPD, 4'h6, 16'h6666);
      chk("dac6", CODE_ZERO, dac[6]);
      ce = 1'b1;
      wt(8);
      chk("dac6", 16'h6666, dac[6]);
   endtask
   task automatic t_ctrl;
      cmd(CMD_PD, 4'h7, 16'hc341);
      chk("pd", 16'hc341, pd);
      cmd(CMD_PD, 4'h8, 16'h0000);
      chk("pd", 16'hc341, pd);
      cmd(CMD_WR_UPD, 4'h0, 16'h0101);
      chk("dac0", 16'h0101, dac[0]);
      cmd(CMD_SETUP, 4'h0, 16'h0005);
      chk("setup", 16'h3, {14'h0, gain_two, ref_off});
      cmd(4'hf, 4'h0, 16'h0000);
      chk("setup", 16'h3, {14'h0, gain_two, ref_off});
      chk("pd", 16'hc341, pd);
   endtask
   task automatic t_resets;
      sel = 1'b1;
      hwr_n = 1'b0;
      wt(4);
      chk("dac1", CODE_MID, dac[1]);
      cmd(CMD_WR_UPD, 4'h1, 16'h7777);
      chk("dac1", CODE_MID, dac[1]);
      hwr_n = 1'b1;
      wt(4);
      chk("dac0", CODE_MID, dac[0]);
      cmd(CMD_WR_UPD, 4'h0, 16'h0202);
      cmd(CMD_SWRST, 4'h1, SWRST_KEY);
      chk("dac0", 16'h0202, dac[0]);
      cmd(CMD_SWRST, SWRST_ADDR, SWRST_KEY);
      wt(12);
      chk("dac0", CODE_MID, dac[0]);
      chk("pd", 16'h0, pd);
   endtask
   task automatic print_verdict;
      if (err_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      wt(8);
      rst_n = 1'b1;
      stb_n = 1'b0;
      wt(4);
      chk("busy", 16'h1, {15'h0, busy});
      stb_n = 1'b1;
      wt(12);
      t_power_up();
      t_strobe();
      t_direct();
      t_freeze();
      t_ctrl();
      t_resets();
      print_verdict();
   end
   // Watchdog well beyond the roughly 6 us the scenarios need.
   initial
   begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule // octal_dac_update_control_test
